// *** rtl/tdd_pkg.sv ***
// Shared constants and types for the trigger settle and decision point block
package tdd_pkg;
   localparam int WB_DW = 32;
   localparam int WB_AW = 8;
   localparam int LINES = 4;
   localparam int LINE_W = 9;
   // Register byte offsets
   localparam logic [7:0] REG_SETTLE = 8'h00;
   localparam logic [7:0] REG_LINE0 = 8'h04;
   localparam logic [7:0] REG_LINE1 = 8'h08;
   localparam logic [7:0] REG_FSEL = 8'h0C;
   localparam logic [7:0] REG_GRAB = 8'h10;
   localparam logic [7:0] REG_LATCHED = 8'h14;
   localparam logic [7:0] REG_STATUS = 8'h18;
   localparam logic [7:0] REG_MASK = 8'h1C;
   localparam logic [7:0] REG_VIDEO = 8'h20;
   // Settle mode field bits, two per line
   localparam int SETTLE_LONG_BIT = 0;
   localparam int SETTLE_DUAL_BIT = 1;
   localparam logic [7:0] SETTLE_RST = 8'h00;
   localparam logic [1:0] LOCK_SHORT_VB = 2'h1;
   localparam logic [1:0] LOCK_LONG_VB = 2'h2;
   // Field selection encodings
   localparam logic [1:0] FIRST_FIELD_SELECT = 2'h1;
   localparam logic [1:0] SECOND_FIELD_SELECT = 2'h2;
   localparam logic [1:0] ANY_FIELD_SELECT = 2'h3;
   localparam logic [1:0] FSEL_RST = ANY_FIELD_SELECT;
   localparam logic [8:0] LINE_MIN = 9'h001;
   localparam logic [8:0] LINE_MAX = 9'h100;
   localparam logic [8:0] LINE0_RST = 9'h009;
   localparam logic [8:0] LINE1_RST = 9'h008;
   // Status bit positions
   localparam int ST_DECIDE_BIT = 4;
   localparam int ST_GRAB_BIT = 5;
   localparam int ST_W = 6;

   typedef struct packed {
      logic deb;
      logic [1:0] lock;
      logic pend;
   } tdd_settle_s;

   typedef struct packed {
      logic vb_s1, vb_s2, vb_prev;
      logic hs_s1, hs_s2, hs_prev;
      logic fld_s1, fld_s2;
      logic [LINES-1:0] trig_s1, trig_s2;
      logic [LINE_W-1:0] line_cnt;
      logic [7:0] settle;
      logic [LINE_W-1:0] line0, line1;
      logic [1:0] fsel;
      logic grab_pend;
      logic grab_go;
      logic decide;
      logic [LINES-1:0] latched;
      logic [ST_W-1:0] status;
      logic [ST_W-1:0] mask;
      logic ack;
      logic [WB_DW-1:0] rdat;
   } tdd_top_s;
endpackage

// *** rtl/tdd_settle_if.sv ***
// Signals between the top and one input line settle unit
`timescale 1ns/10ps
interface tdd_settle_if;
   logic [1:0] mode;
   logic level;
   logic vb_tick;
   logic consume;
   logic edge_pulse;
   logic pend;
   modport unit (input mode, input level, input vb_tick, input consume, output edge_pulse, output pend);
   modport ctl (output mode, output level, output vb_tick, output consume, input edge_pulse, input pend);
endinterface

// *** rtl/tdd_settle.sv ***
// Settle lockout and edge latch for one digital input line
`timescale 1ns/10ps
module tdd_settle (
   input wire logic clock_in,
   input wire logic srst_in,
   tdd_settle_if.unit sif
);
   import tdd_pkg::*;
   tdd_settle_s st_ff, nxt_st;
   logic edge_w;

   function automatic logic [1:0] lock_len(input logic [1:0] mode);
      lock_len = mode[SETTLE_LONG_BIT] ? LOCK_LONG_VB : LOCK_SHORT_VB;
   endfunction

   always_comb begin
      nxt_st = st_ff;
      edge_w = 1'b0;
      if (sif.vb_tick && st_ff.lock != 2'h0) begin
         nxt_st.lock = st_ff.lock - 2'h1;
      end
      if (st_ff.lock == 2'h0 && sif.level != st_ff.deb) begin
         nxt_st.deb = sif.level;
         if (sif.level) begin
            edge_w = 1'b1;
            nxt_st.lock = lock_len(sif.mode);
         end else if (sif.mode[SETTLE_DUAL_BIT]) begin
            nxt_st.lock = lock_len(sif.mode);
         end
      end
      if (sif.consume) begin
         nxt_st.pend = 1'b0;
      end
      if (edge_w) begin
         nxt_st.pend = 1'b1;
      end
   end

   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign sif.edge_pulse = edge_w;
   assign sif.pend = st_ff.pend;

   a_lock_freeze: assert property (@(posedge clock_in) disable iff (srst_in)
      st_ff.lock != 2'h0 |=> st_ff.deb == $past(st_ff.deb))
      else $error("debounced level moved during lockout");
   a_edge_lock_len: assert property (@(posedge clock_in) disable iff (srst_in)
      edge_w |=> st_ff.lock == ($past(sif.mode[SETTLE_LONG_BIT]) ? LOCK_LONG_VB : LOCK_SHORT_VB))
      else $error("wrong lockout length after edge");
   a_return_free: assert property (@(posedge clock_in) disable iff (srst_in)
      (st_ff.lock == 2'h0 && st_ff.deb && !sif.level && !sif.mode[SETTLE_DUAL_BIT]) |=> st_ff.lock == 2'h0)
      else $error("return edge locked without dual mode");
   a_return_locked: assert property (@(posedge clock_in) disable iff (srst_in)
      (st_ff.lock == 2'h0 && st_ff.deb && !sif.level && sif.mode[SETTLE_DUAL_BIT]) |=> st_ff.lock != 2'h0)
      else $error("return edge not locked in dual mode");
endmodule

// *** rtl/tdd_trigger_top.sv ***
// Trigger input settle, vertical blank decision point and Wishbone registers
`timescale 1ns/10ps
module tdd_trigger_top #(
   parameter bit HAS_CTRL = 1'b1
) (
   input wire logic clock_in,
   input wire logic srst_in,
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   input wire logic wb_we_in,
   input wire logic [tdd_pkg::WB_AW-1:0] wb_adr_in,
   input wire logic [tdd_pkg::WB_DW-1:0] wb_dat_in,
   input wire logic [3:0] wb_sel_in,
   output logic [tdd_pkg::WB_DW-1:0] wb_dat_out,
   output logic wb_ack_out,
   input wire logic vblank_in,
   input wire logic hsync_in,
   input wire logic field_in,
   input wire logic [tdd_pkg::LINES-1:0] trig_in,
   output logic queue_service_out,
   output logic grab_go_out,
   output logic [tdd_pkg::LINES-1:0] latched_out,
   output logic irq_out
);
   import tdd_pkg::*;

   tdd_top_s st_ff, nxt_st;
   logic [LINES-1:0] pend_w;
   logic [LINES-1:0] edge_w;
   logic vb_tick;
   logic hs_tick;
   logic hit;
   logic access;
   logic [WB_DW-1:0] wdat;
   logic [WB_DW-1:0] rsel;
   logic [LINE_W-1:0] target;
   logic fld_en;
   logic [LINE_W-1:0] line_next;

   // Byte-lane merge of write data into a register
   function automatic logic [WB_DW-1:0] wb_merge(input logic [WB_DW-1:0] old_v,
                                                 input logic [WB_DW-1:0] new_v,
                                                 input logic [3:0] sel);
      logic [WB_DW-1:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            r[b*8 +: 8] = new_v[b*8 +: 8];
         end
      end
      wb_merge = r;
   endfunction

   function automatic logic line_ok(input logic [LINE_W-1:0] v);
      line_ok = (v >= LINE_MIN) && (v <= LINE_MAX);
   endfunction

   generate
      for (genvar gi = 0; gi < LINES; gi++) begin : g_line
         tdd_settle_if sif();
         // Mode forced to zero without controls
         assign sif.mode = HAS_CTRL ? st_ff.settle[gi*2 +: 2] : 2'h0;
         assign sif.level = st_ff.trig_s2[gi];
         assign sif.vb_tick = vb_tick;
         assign sif.consume = hit;
         assign pend_w[gi] = sif.pend;
         assign edge_w[gi] = sif.edge_pulse;
         tdd_settle tdd_settle_i (
            .clock_in(clock_in),
            .srst_in(srst_in),
            .sif(sif)
         );
      end
   endgenerate

   assign vb_tick = st_ff.vb_s2 && !st_ff.vb_prev;
   assign hs_tick = st_ff.hs_s2 && !st_ff.hs_prev;
   assign line_next = (st_ff.line_cnt == {LINE_W{1'b1}}) ? st_ff.line_cnt : st_ff.line_cnt + 9'h001;
   assign target = st_ff.fld_s2 ? st_ff.line1 : st_ff.line0;
   assign fld_en = st_ff.fld_s2 ? st_ff.fsel[1] : st_ff.fsel[0];
   assign hit = hs_tick && st_ff.vb_s2 && fld_en && (line_next == target);
   assign access = wb_cyc_in && wb_stb_in && !st_ff.ack;

   always_comb begin
      rsel = '0;
      case (wb_adr_in)
         REG_SETTLE: begin
            rsel = {24'h000000, HAS_CTRL ? st_ff.settle : 8'h00};
         end
         REG_LINE0: begin
            rsel = {23'h000000, st_ff.line0};
         end
         REG_LINE1: begin
            rsel = {23'h000000, st_ff.line1};
         end
         REG_FSEL: begin
            rsel = {30'h00000000, st_ff.fsel};
         end
         REG_GRAB: begin
            rsel = {31'h00000000, st_ff.grab_pend};
         end
         REG_LATCHED: begin
            rsel = {24'h000000, pend_w, st_ff.latched};
         end
         REG_STATUS: begin
            rsel = {26'h0000000, st_ff.status};
         end
         REG_MASK: begin
            rsel = {26'h0000000, st_ff.mask};
         end
         REG_VIDEO: begin
            rsel = {20'h00000, st_ff.fld_s2, st_ff.vb_s2, 1'b0, st_ff.line_cnt};
         end
         default: begin
            rsel = '0;
         end
      endcase
   end

   always_comb begin
      nxt_st = st_ff;
      wdat = '0;
      nxt_st.vb_s1 = vblank_in;
      nxt_st.vb_s2 = st_ff.vb_s1;
      nxt_st.vb_prev = st_ff.vb_s2;
      nxt_st.hs_s1 = hsync_in;
      nxt_st.hs_s2 = st_ff.hs_s1;
      nxt_st.hs_prev = st_ff.hs_s2;
      nxt_st.fld_s1 = field_in;
      nxt_st.fld_s2 = st_ff.fld_s1;
      nxt_st.trig_s1 = trig_in;
      nxt_st.trig_s2 = st_ff.trig_s1;
      if (vb_tick) begin
         nxt_st.line_cnt = '0;
      end else if (hs_tick) begin
         nxt_st.line_cnt = line_next;
      end
      nxt_st.decide = hit;
      nxt_st.grab_go = 1'b0;
      if (hit) begin
         nxt_st.latched = pend_w;
         if (st_ff.grab_pend) begin
            nxt_st.grab_go = 1'b1;
            nxt_st.grab_pend = 1'b0;
         end
      end
      nxt_st.ack = access;
      nxt_st.rdat = access && !wb_we_in ? rsel : st_ff.rdat;
      if (access && wb_we_in) begin
         wdat = wb_merge(rsel, wb_dat_in, wb_sel_in);
         case (wb_adr_in)
            REG_SETTLE: begin
               if (HAS_CTRL) begin
                  nxt_st.settle = wdat[7:0];
               end
            end
            REG_LINE0: begin
               if (line_ok(wdat[LINE_W-1:0])) begin
                  nxt_st.line0 = wdat[LINE_W-1:0];
               end
            end
            REG_LINE1: begin
               if (line_ok(wdat[LINE_W-1:0])) begin
                  nxt_st.line1 = wdat[LINE_W-1:0];
               end
            end
            REG_FSEL: begin
               nxt_st.fsel = wdat[1:0];
            end
            REG_GRAB: begin
               if (wdat[0]) begin
                  nxt_st.grab_pend = 1'b1;
               end
            end
            REG_STATUS: begin
               nxt_st.status = st_ff.status & ~wdat[ST_W-1:0];
            end
            REG_MASK: begin
               nxt_st.mask = wdat[ST_W-1:0];
            end
            default: begin
            end
         endcase
      end
      // Events set after software clear so they win
      nxt_st.status[LINES-1:0] = nxt_st.status[LINES-1:0] | edge_w;
      nxt_st.status[ST_DECIDE_BIT] = nxt_st.status[ST_DECIDE_BIT] | hit;
      nxt_st.status[ST_GRAB_BIT] = nxt_st.status[ST_GRAB_BIT] | nxt_st.grab_go;
   end

   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         st_ff <= '0;
         st_ff.settle <= SETTLE_RST;
         st_ff.line0 <= LINE0_RST;
         st_ff.line1 <= LINE1_RST;
         st_ff.fsel <= FSEL_RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign wb_dat_out = st_ff.rdat;
   assign wb_ack_out = st_ff.ack;
   assign queue_service_out = st_ff.decide;
   assign grab_go_out = st_ff.grab_go;
   assign latched_out = st_ff.latched;
   assign irq_out = |(st_ff.status & st_ff.mask);

   a_ack_next: assert property (@(posedge clock_in) disable iff (srst_in)
      (wb_cyc_in && wb_stb_in && !wb_ack_out) |=> wb_ack_out)
      else $error("no ack one cycle after request");
   a_ack_single: assert property (@(posedge clock_in) disable iff (srst_in)
      wb_ack_out |=> !wb_ack_out)
      else $error("ack held longer than one cycle");
   a_decide_latch: assert property (@(posedge clock_in) disable iff (srst_in)
      hit |=> queue_service_out && latched_out == $past(pend_w))
      else $error("edges not latched at decision point");
   a_consume_clear: assert property (@(posedge clock_in) disable iff (srst_in)
      hit |=> pend_w == $past(edge_w))
      else $error("latched edge not consumed at decision");
   a_grab_decide: assert property (@(posedge clock_in) disable iff (srst_in)
      (hit && st_ff.grab_pend) |=> grab_go_out ##1 !grab_go_out)
      else $error("pending grab not decided at decision point");
   a_line_range: assert property (@(posedge clock_in) disable iff (srst_in)
      line_ok(st_ff.line0) && line_ok(st_ff.line1))
      else $error("decision line out of range");
   a_build_zero: assert property (@(posedge clock_in) disable iff (srst_in)
      !HAS_CTRL |-> g_line[0].sif.mode == 2'h0 && rsel[7:0] == 8'h00 || wb_adr_in != REG_SETTLE)
      else $error("settle mode nonzero without controls");
   a_reset_mode: assert property (@(posedge clock_in)
      $past(srst_in) |-> st_ff.settle == SETTLE_RST)
      else $error("settle mode not zero after reset");
endmodule

// *** dv/tdd_video_model.sv ***
// Video timing source for the trigger block bench
`timescale 1ns/10ps
module tdd_video_model (
   input wire logic clock_in,
   input wire logic srst_in,
   output logic vblank_out,
   output logic hsync_out,
   output logic field_out
);
   logic [7:0] cnt_ff;
   // Field of 24 lines of 8 cycles, blank for the first 20
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         cnt_ff <= 8'h00;
         field_out <= 1'b0;
      end else begin
         cnt_ff <= (cnt_ff == 8'hBF) ? 8'h00 : cnt_ff + 8'h01;
         if (cnt_ff == 8'hBF) begin
            field_out <= ~field_out;
         end
      end
   end
   assign vblank_out = cnt_ff < 8'hA0;
   assign hsync_out = cnt_ff[2:0] == 3'h4;
endmodule

// *** dv/tdd_trigger_top_tb.sv ***
// Self-checking bench for the trigger settle and decision point block
`timescale 1ns/10ps
module tdd_trigger_top_tb;
   import tdd_pkg::*;
   logic clock_in, srst_in, cyc, stb, we, vb, hs, fld, ack, qs, go, irq;
   logic [7:0] adr;
   logic [31:0] wdat, rd, rd_b, q, qb;
   logic [3:0] sel, trig, lat;
   int num_errors = 0;
   int checks_done = 0;
   initial begin
      clock_in = 1'b0;
      forever #2.5 clock_in = ~clock_in;
   end
   tdd_video_model tdd_video_model_i (.clock_in(clock_in), .srst_in(srst_in), .vblank_out(vb),
      .hsync_out(hs), .field_out(fld));
   tdd_trigger_top tdd_trigger_top_i (.clock_in(clock_in), .srst_in(srst_in), .wb_cyc_in(cyc),
      .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_dat_in(wdat), .wb_sel_in(sel),
      .wb_dat_out(rd), .wb_ack_out(ack), .vblank_in(vb), .hsync_in(hs), .field_in(fld),
      .trig_in(trig), .queue_service_out(qs), .grab_go_out(go), .latched_out(lat), .irq_out(irq));
   // Build without control features, sharing the bus
   tdd_trigger_top #(.HAS_CTRL(1'b0)) tdd_trigger_top_b_i (.clock_in(clock_in), .srst_in(srst_in),
      .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_dat_in(wdat),
      .wb_sel_in(sel), .wb_dat_out(rd_b), .wb_ack_out(), .vblank_in(vb), .hsync_in(hs),
      .field_in(fld), .trig_in(trig), .queue_service_out(), .grab_go_out(), .latched_out(),
      .irq_out());
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clock_in);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do begin
         @(posedge clock_in);
         n++;
      end while (ack !== 1'b1 && n < 20);
      if (ack !== 1'b1) begin
         num_errors++;
         $display("FAIL t=%0t got=%h exp=%h", $time, ack, 1'b1);
      end
      q = rd;
      qb = rd_b;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask
   task automatic wait_dec;
      int n;
      n = 0;
      do begin
         @(posedge clock_in);
         n++;
      end while (qs !== 1'b1 && n < 400);
      if (qs !== 1'b1) begin
         num_errors++;
         $display("FAIL t=%0t got=%h exp=%h", $time, qs, 1'b1);
      end
   endtask
   task automatic tset(input int n, input logic v);
      @(posedge clock_in);
      trig[n] <= v;
      repeat (6) @(posedge clock_in);
   endtask
   task automatic test_regs;
      logic [7:0] ra[5];
      logic [31:0] re[5];
      ra = '{REG_SETTLE, REG_LINE0, REG_LINE1, REG_FSEL, 8'h3C};
      re = '{32'h0, 32'h9, 32'h8, 32'h3, 32'h0};
      for (int i = 0; i < 5; i++) begin
         wb(1'b0, ra[i], 32'h0);
         chk(q, re[i]);
      end
      wb(1'b1, REG_SETTLE, 32'hFF);
      wb(1'b0, REG_SETTLE, 32'h0);
      chk(q, 32'hFF);
      chk(qb, 32'h0);
      // Back to mode zero so later edges see only the short one-blank lockout after a rising edge
      wb(1'b1, REG_SETTLE, 32'h0);
      $display("test regs done");
   endtask
   task automatic test_line;
      logic [31:0] wv[4];
      logic [31:0] ev[4];
      int n;
      wv = '{32'h0, 32'h101, 32'h100, 32'h3};
      ev = '{32'h9, 32'h9, 32'h100, 32'h3};
      // Last value kept inside 1 to 256
      for (int i = 0; i < 4; i++) begin
         wb(1'b1, REG_LINE0, wv[i]);
         wb(1'b0, REG_LINE0, 32'h0);
         chk(q, ev[i]);
      end
      n = 0;
      do @(posedge vb); while (fld !== 1'b0);
      do begin
         @(posedge clock_in);
         n++;
      end while (qs !== 1'b1 && n < 400);
      chk({31'h0, n >= 23 && n <= 27}, 32'h1);
      $display("test line done");
   endtask
   task automatic test_fsel;
      int c[4];
      c = '{0, 1, 1, 2};
      for (int f = 0; f < 4; f++) begin
         int n;
         n = 0;
         wb(1'b1, REG_FSEL, f);
         repeat (384) begin
            @(posedge clock_in);
            if (qs === 1'b1) begin
               n++;
               if (f == 1 || f == 2) chk(fld, f - 1);
            end
         end
         chk(n, c[f]);
      end
      $display("test fsel done");
   endtask
   task automatic test_latch;
      wb(1'b1, REG_MASK, 32'h1);
      wait_dec();
      wb(1'b1, REG_STATUS, 32'h3F);
      wb(1'b1, REG_GRAB, 32'h1);
      wb(1'b0, REG_GRAB, 32'h0);
      chk(q, 32'h1);
      tset(0, 1'b1);
      wait_dec();
      chk(lat, 4'h1);
      chk(go, 1'b1);
      chk(vb, 1'b1);
      chk(irq, 1'b1);
      wb(1'b1, REG_STATUS, 32'h3F);
      chk(irq, 1'b0);
      wb(1'b0, REG_LATCHED, 32'h0);
      chk(q, 32'h1);
      wait_dec();
      chk(lat, 4'h0);
      chk(go, 1'b0);
      tset(0, 1'b0);
      $display("test latch done");
   endtask
   task automatic test_settle(input int n, input logic [1:0] m, input logic e1, input logic e2);
      wb(1'b1, REG_SETTLE, 32'(m) << (2 * n));
      @(negedge vb);
      tset(n, 1'b1);
      tset(n, 1'b0);
      wb(1'b1, REG_STATUS, 32'h3F);
      @(posedge vb);
      repeat (10) @(posedge clock_in);
      tset(n, 1'b1);
      wb(1'b0, REG_STATUS, 32'h0);
      chk(q[n], e1);
      chk(qb[n], 1'b1);
      wb(1'b1, REG_STATUS, 32'h3F);
      tset(n, 1'b0);
      @(posedge vb);
      repeat (10) @(posedge clock_in);
      tset(n, 1'b1);
      wb(1'b0, REG_STATUS, 32'h0);
      chk(q[n], e2);
      chk(qb[n], 1'b1);
      tset(n, 1'b0);
      $display("test settle %0d done", n);
   endtask
   task automatic wrap_up;
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clock_in);
      num_errors++;
      wrap_up();
   end
   initial begin
      srst_in = 1'b1;
      {cyc, stb, we} = 3'h0;
      adr = 8'h00;
      wdat = 32'h0;
      sel = 4'hF;
      trig = 4'h0;
      repeat (2) @(posedge clock_in);
      srst_in <= 1'b0;
      test_regs();
      test_line();
      test_fsel();
      test_latch();
      test_settle(0, 2'h0, 1'b1, 1'b1);
      test_settle(1, 2'h1, 1'b0, 1'b1);
      test_settle(2, 2'h2, 1'b0, 1'b1);
      test_settle(3, 2'h3, 1'b0, 1'b0);
      wrap_up();
   end
endmodule
